// File: ccu_unit.sv
// Capture/compare unit: value and control registers, capture, compare, trigger.
// Assumes a single-cycle register port and a pin resolved by the surroundings.
//
// Notes on behaviour
// - Value is two readable, writable bytes beside a readable, writable control register.
// - Capture and compare both use the sixteen-bit time base.
// - A capture event copies the whole time base count into the value.
// - Mode selects falling, rising, every 4th rising or every 16th rising edge.
// - Each capture sets the unit flag; it stays until software clears it.
// - A new capture overwrites the value even if unread.
// - Capture looks at the pin level even while the pin is driven.
// - Mode changes may raise a false flag; software masks, then clears it.
// - Prescaler count clears when off or outside capture modes.
// - Moving between capture settings keeps the prescaler count.
// - Compare match drives the pin high, low or leaves it, per mode.
// - Every compare match sets the unit flag.
// - Writing zero to control forces the compare output latch low.
// - Software-interrupt compare leaves the pin alone and only flags.
// - Trigger mode match clears the time base and starts a conversion.
// - Mode 1011 selects the special event trigger.
// - A time base write in the trigger cycle wins over the clear.
// - A trigger clear does not set the time base overflow flag.
`timescale 1ns/1ps
`default_nettype none
module ccu_unit
    import ccu_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire ccu_bus_req_s bus_i,
    output logic [7:0]        rdata_o,
    input  wire logic         pin_i,
    output logic              pin_o,
    output logic              pin_oe_o,
    input  wire logic         adc_enable_i,
    output logic              adc_start_o,
    output logic              unit_irq_o,
    output logic              time_base_irq_o
);
    logic [7:0]  value_low_r;
    logic [7:0]  value_high_r;
    logic [7:0]  ctrl_r;
    logic [7:0]  flags_r;
    logic [7:0]  enables_r;
    logic [7:0]  tb_ctrl_r;
    logic [7:0]  port_dir_r;
    logic [7:0]  port_data_r;
    logic        cmp_latch_r;
    logic        match_q_r;
    logic        adc_start_r;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;

    logic [3:0]  mode;
    logic [15:0] value;
    logic [15:0] tb_count;
    logic        tb_overflow;
    logic        cap_event;
    logic [3:0]  presc;
    logic        cmp_on;
    logic        match;
    logic        hit;
    logic        trig;
    logic        cmp_drives;

    logic        wr_val_low;
    logic        wr_val_high;
    logic        wr_ctrl;
    logic        wr_flags;
    logic        wr_tb_low;
    logic        wr_tb_high;

    assign mode  = ctrl_r[3:0];
    assign value = {value_high_r, value_low_r};

    assign wr_val_low  = bus_i.wr && (bus_i.addr == CCU_ADDR_VAL_LOW);
    assign wr_val_high = bus_i.wr && (bus_i.addr == CCU_ADDR_VAL_HIGH);
    assign wr_ctrl     = bus_i.wr && (bus_i.addr == CCU_ADDR_CTRL);
    assign wr_flags    = bus_i.wr && (bus_i.addr == CCU_ADDR_FLAGS);
    assign wr_tb_low   = bus_i.wr && (bus_i.addr == CCU_ADDR_TB_LOW);
    assign wr_tb_high  = bus_i.wr && (bus_i.addr == CCU_ADDR_TB_HIGH);

    ccu_time_base u_time_base (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .run_i      (tb_ctrl_r[CCU_TB_RUN_BIT]),
        .wr_low_i   (wr_tb_low),
        .wr_high_i  (wr_tb_high),
        .wdata_i    (bus_i.wdata),
        .clear_i    (trig),
        .count_o    (tb_count),
        .overflow_o (tb_overflow)
    );

    // The resolved wire is watched, so a port write on a driven pin can capture
    ccu_pin_edge u_pin_edge (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (pin_i),
        .mode_i  (mode),
        .event_o (cap_event),
        .presc_o (presc)
    );

    // Compare fires once per arrival at the value, not every cycle it holds
    assign cmp_on = (mode[3:2] == CCU_CMP_GROUP);
    assign match  = cmp_on && (tb_count == value);
    assign hit    = match && !match_q_r;
    assign trig   = hit && (mode == CCU_MODE_CMP_TRIG);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            match_q_r <= 1'b0;
        end else begin
            match_q_r <= match;
        end
    end

    // Capture beats a software write in the same cycle, so no event is dropped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_low_r  <= CCU_VALUE_RST;
            value_high_r <= CCU_VALUE_RST;
        end else if (cap_event) begin
            value_low_r  <= tb_count[7:0];
            value_high_r <= tb_count[15:8];
        end else begin
            if (wr_val_low) begin
                value_low_r <= bus_i.wdata;
            end
            if (wr_val_high) begin
                value_high_r <= bus_i.wdata;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= CCU_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= bus_i.wdata & CCU_CTRL_MASK;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_latch_r <= 1'b0;
        end else if (wr_ctrl && (bus_i.wdata == CCU_CTRL_RST)) begin
            cmp_latch_r <= 1'b0;
        end else if (hit) begin
            case (mode)
                CCU_MODE_CMP_HIGH: cmp_latch_r <= 1'b1;
                CCU_MODE_CMP_LOW:  cmp_latch_r <= 1'b0;
                default:           cmp_latch_r <= cmp_latch_r;
            endcase
        end
    end

    // Hardware set wins over a software clear landing in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_r <= 8'h00;
        end else begin
            if (wr_flags) begin
                flags_r[CCU_UNIT_FLAG_BIT] <= bus_i.wdata[CCU_UNIT_FLAG_BIT];
                flags_r[CCU_TB_OVF_BIT]    <= bus_i.wdata[CCU_TB_OVF_BIT];
            end
            if (cap_event || hit) begin
                flags_r[CCU_UNIT_FLAG_BIT] <= 1'b1;
            end
            if (tb_overflow) begin
                flags_r[CCU_TB_OVF_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enables_r   <= 8'h00;
            tb_ctrl_r   <= 8'h00;
            port_dir_r  <= CCU_PORT_DIR_RST;
            port_data_r <= CCU_PORT_DATA_RST;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                CCU_ADDR_ENABLES:   enables_r   <= bus_i.wdata;
                CCU_ADDR_TB_CTRL:   tb_ctrl_r   <= bus_i.wdata;
                CCU_ADDR_PORT_DIR:  port_dir_r  <= bus_i.wdata;
                CCU_ADDR_PORT_DATA: port_data_r <= bus_i.wdata;
                default:            tb_ctrl_r   <= tb_ctrl_r;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            adc_start_r <= 1'b0;
        end else begin
            adc_start_r <= trig && adc_enable_i;
        end
    end

    // The pin shows the compare latch only in the driving compare modes
    assign cmp_drives = (mode == CCU_MODE_CMP_HIGH) || (mode == CCU_MODE_CMP_LOW);
    assign pin_o      = cmp_drives ? cmp_latch_r : port_data_r[CCU_PIN_BIT];
    assign pin_oe_o   = !port_dir_r[CCU_PIN_BIT];

    always_comb begin
        rdata_nxt = 8'h00;
        if (bus_i.rd) begin
            case (bus_i.addr)
                CCU_ADDR_VAL_LOW:   rdata_nxt = value_low_r;
                CCU_ADDR_VAL_HIGH:  rdata_nxt = value_high_r;
                CCU_ADDR_CTRL:      rdata_nxt = ctrl_r;
                CCU_ADDR_FLAGS:     rdata_nxt = flags_r;
                CCU_ADDR_ENABLES:   rdata_nxt = enables_r;
                CCU_ADDR_TB_LOW:    rdata_nxt = tb_count[7:0];
                CCU_ADDR_TB_HIGH:   rdata_nxt = tb_count[15:8];
                CCU_ADDR_TB_CTRL:   rdata_nxt = tb_ctrl_r;
                CCU_ADDR_PORT_DIR:  rdata_nxt = port_dir_r;
                CCU_ADDR_PORT_DATA: rdata_nxt = port_data_r;
                default:            rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o         = rdata_r;
    assign adc_start_o     = adc_start_r;
    assign unit_irq_o      = flags_r[CCU_UNIT_FLAG_BIT] && enables_r[CCU_UNIT_FLAG_BIT];
    assign time_base_irq_o = flags_r[CCU_TB_OVF_BIT] && enables_r[CCU_TB_OVF_BIT];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    capture_load_a: assert property (
        cap_event |=> value == $past(tb_count))
        else $error("capture did not load the time base");
    capture_flag_a: assert property (
        cap_event |=> flags_r[CCU_UNIT_FLAG_BIT])
        else $error("capture did not set the unit flag");
    flag_holds_a: assert property (
        flags_r[CCU_UNIT_FLAG_BIT] && !wr_flags |=> flags_r[CCU_UNIT_FLAG_BIT])
        else $error("unit flag dropped without software");
    match_flag_a: assert property (
        hit |=> flags_r[CCU_UNIT_FLAG_BIT])
        else $error("compare match did not set the unit flag");
    cmp_high_a: assert property (
        hit && mode == CCU_MODE_CMP_HIGH && !wr_ctrl |=> cmp_latch_r ##0 pin_o)
        else $error("compare high did not drive the pin high");
    cmp_low_a: assert property (
        hit && mode == CCU_MODE_CMP_LOW && !wr_ctrl |=> !cmp_latch_r ##0 !pin_o)
        else $error("compare low did not drive the pin low");
    soft_pin_a: assert property (
        hit && mode == CCU_MODE_CMP_SOFT && !wr_ctrl |=> $stable(cmp_latch_r))
        else $error("software compare touched the pin latch");
    latch_clear_a: assert property (
        wr_ctrl && bus_i.wdata == CCU_CTRL_RST |=> !cmp_latch_r)
        else $error("control zero did not clear the compare latch");
    trig_adc_a: assert property (
        trig && adc_enable_i |=> adc_start_o ##1 !adc_start_o)
        else $error("trigger did not start one conversion");

    // Register port: a write lands on its edge, a read answers for one cycle only
    val_low_wr_a: assert property (
        wr_val_low && !cap_event |=> value_low_r == $past(bus_i.wdata))
        else $error("value low write lost");

    ctrl_wr_a: assert property (
        wr_ctrl |=> ctrl_r == ($past(bus_i.wdata) & CCU_CTRL_MASK))
        else $error("control write lost");

    rd_value_a: assert property (
        bus_i.rd && bus_i.addr == CCU_ADDR_VAL_HIGH |=> rdata_o == $past(value_high_r))
        else $error("value high read wrong");

    rd_idle_a: assert property (
        !bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data outside its cycle");

    // Capture: only the selected edges, always overwriting
    cap_idle_a: assert property (
        mode[3:2] != CCU_CAP_GROUP |-> !cap_event)
        else $error("capture outside capture modes");

    cap_high_a: assert property (
        cap_event |=> value_high_r == $past(tb_count[15:8]))
        else $error("capture did not overwrite the value");

    value_hold_a: assert property (
        !cap_event && !wr_val_low |=> $stable(value_low_r))
        else $error("value changed with no capture or write");

    presc_keep_a: assert property (
        mode[3:2] == CCU_CAP_GROUP && wr_ctrl && bus_i.wdata[3:2] == CCU_CAP_GROUP
        |=> presc == $past(presc) || presc == $past(presc) + 4'h1)
        else $error("prescaler lost across a setting change");

    presc_off_a: assert property (
        mode == CCU_MODE_OFF |=> presc == CCU_PRESC_RST)
        else $error("prescaler not cleared while off");

    // Compare and trigger
    cmp_hold_a: assert property (
        cmp_on && !hit && !wr_ctrl |=> $stable(cmp_latch_r))
        else $error("compare latch moved without a match");

    trig_tb_a: assert property (
        hit && mode == CCU_MODE_CMP_TRIG && !wr_tb_low && !wr_tb_high
        |=> tb_count == CCU_TB_RST)
        else $error("trigger match did not clear the time base");

    no_trig_a: assert property (
        hit && mode != CCU_MODE_CMP_TRIG |=> !adc_start_o)
        else $error("conversion started outside trigger mode");

    adc_off_a: assert property (
        trig && !adc_enable_i |=> !adc_start_o)
        else $error("conversion started while disabled");

    tb_wr_wins_a: assert property (
        trig && wr_tb_high |=> tb_count[15:8] == $past(bus_i.wdata))
        else $error("trigger clear beat a time base write");

    no_ovf_flag_a: assert property (
        trig && !wr_flags && !flags_r[CCU_TB_OVF_BIT] |=> !flags_r[CCU_TB_OVF_BIT])
        else $error("trigger clear set the overflow flag");

    set_wins_a: assert property (
        (cap_event || hit) && wr_flags |=> flags_r[CCU_UNIT_FLAG_BIT])
        else $error("software clear beat a hardware set");
endmodule
`default_nettype wire

// File: ccu_pkg.sv
// Constants, field positions and bus carrier for the capture/compare unit.
// Assumes one 20 MHz clock and an 8-bit register port.
package ccu_pkg;

    localparam logic [7:0] CCU_ADDR_PORT_DATA = 8'h07;
    localparam logic [7:0] CCU_ADDR_FLAGS     = 8'h0c;
    localparam logic [7:0] CCU_ADDR_TB_LOW    = 8'h0e;
    localparam logic [7:0] CCU_ADDR_TB_HIGH   = 8'h0f;
    localparam logic [7:0] CCU_ADDR_TB_CTRL   = 8'h10;
    localparam logic [7:0] CCU_ADDR_VAL_LOW   = 8'h15;
    localparam logic [7:0] CCU_ADDR_VAL_HIGH  = 8'h16;
    localparam logic [7:0] CCU_ADDR_CTRL      = 8'h17;
    localparam logic [7:0] CCU_ADDR_PORT_DIR  = 8'h87;
    localparam logic [7:0] CCU_ADDR_ENABLES   = 8'h8c;

    localparam int CCU_UNIT_FLAG_BIT = 2;
    localparam int CCU_TB_OVF_BIT    = 0;
    localparam int CCU_PIN_BIT       = 2;
    localparam int CCU_TB_RUN_BIT    = 0;

    localparam logic [7:0] CCU_CTRL_RST      = 8'h00;
    localparam logic [7:0] CCU_CTRL_MASK     = 8'h3f;
    localparam logic [7:0] CCU_PORT_DIR_RST  = 8'hff;
    localparam logic [7:0] CCU_PORT_DATA_RST = 8'h00;
    localparam logic [7:0] CCU_VALUE_RST     = 8'h00;
    localparam logic [15:0] CCU_TB_RST       = 16'h0000;
    localparam logic [15:0] CCU_TB_MAX       = 16'hffff;

    localparam logic [3:0] CCU_MODE_OFF      = 4'h0;
    localparam logic [3:0] CCU_MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] CCU_MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] CCU_MODE_CAP_4TH  = 4'h6;
    localparam logic [3:0] CCU_MODE_CAP_16TH = 4'h7;
    localparam logic [3:0] CCU_MODE_CMP_HIGH = 4'h8;
    localparam logic [3:0] CCU_MODE_CMP_LOW  = 4'h9;
    localparam logic [3:0] CCU_MODE_CMP_SOFT = 4'ha;
    localparam logic [3:0] CCU_MODE_CMP_TRIG = 4'hb;
    localparam logic [1:0] CCU_CAP_GROUP     = 2'h1;
    localparam logic [1:0] CCU_CMP_GROUP     = 2'h2;

    localparam logic [3:0] CCU_PRESC_4TH_LAST  = 4'h3;
    localparam logic [3:0] CCU_PRESC_16TH_LAST = 4'hf;
    localparam logic [3:0] CCU_PRESC_RST       = 4'h0;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ccu_bus_req_s;

endpackage

// File: ccu_pin_edge.sv
// Pin synchroniser, edge detector and capture edge prescaler.
// Assumes the pin level is the resolved wire, whoever drives it.
`timescale 1ns/1ps
`default_nettype none
module ccu_pin_edge
    import ccu_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       pin_i,
    input  wire logic [3:0] mode_i,
    output logic            event_o,
    output logic [3:0]      presc_o
);
    logic       sync1_r;
    logic       sync2_r;
    logic       prev_r;
    logic [3:0] presc_r;
    logic       rise;
    logic       fall;
    logic       capture_on;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign rise       = sync2_r & ~prev_r;
    assign fall       = ~sync2_r & prev_r;
    assign capture_on = (mode_i[3:2] == CCU_CAP_GROUP);

    // Count survives a move between capture settings, so a stale count may fire early
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            presc_r <= CCU_PRESC_RST;
        end else if (!capture_on) begin
            presc_r <= CCU_PRESC_RST;
        end else if (rise) begin
            presc_r <= presc_r + 4'h1;
        end
    end

    always_comb begin
        case (mode_i)
            CCU_MODE_CAP_FALL: event_o = fall;
            CCU_MODE_CAP_RISE: event_o = rise;
            CCU_MODE_CAP_4TH:  event_o = rise && (presc_r[1:0] == CCU_PRESC_4TH_LAST[1:0]);
            CCU_MODE_CAP_16TH: event_o = rise && (presc_r == CCU_PRESC_16TH_LAST);
            default:           event_o = 1'b0;
        endcase
    end

    assign presc_o = presc_r;

    presc_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !capture_on |=> presc_r == CCU_PRESC_RST)
        else $error("prescaler not cleared outside capture");
endmodule
`default_nettype wire

// File: ccu_time_base.sv
// Sixteen-bit time base with byte writes, trigger clear and overflow pulse.
// Assumes writes and the trigger are one-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none
module ccu_time_base
    import ccu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        run_i,
    input  wire logic        wr_low_i,
    input  wire logic        wr_high_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        clear_i,
    output logic [15:0]      count_o,
    output logic             overflow_o
);
    logic [15:0] count_r;
    logic        sw_write;

    assign sw_write = wr_low_i | wr_high_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_r <= CCU_TB_RST;
        end else if (wr_low_i) begin
            count_r[7:0] <= wdata_i;
        end else if (wr_high_i) begin
            count_r[15:8] <= wdata_i;
        end else if (clear_i) begin
            count_r <= CCU_TB_RST;
        end else if (run_i) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // A trigger clear never counts as a rollover
    assign overflow_o = run_i && !sw_write && !clear_i && (count_r == CCU_TB_MAX);
    assign count_o    = count_r;

    write_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_low_i && clear_i |=> count_r[7:0] == $past(wdata_i))
        else $error("trigger clear beat a time base write");
    trig_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clear_i && !sw_write |=> count_r == CCU_TB_RST)
        else $error("trigger did not clear the time base");
    no_ovf_trig_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clear_i |-> !overflow_o)
        else $error("trigger clear raised overflow");
endmodule
`default_nettype wire

// File: ccu_pin_model.sv
// Source or load on the capture/compare pin, and the resolved pin level.
// Assumes the unit's level wins for the one cycle the bench source and the unit both drive the pin.
`timescale 1ns/1ps
`default_nettype none
module ccu_pin_model (
    input  wire logic clk_i,
    input  wire logic unit_pin_i,
    input  wire logic unit_oe_i,
    input  wire logic src_en_i,
    input  wire logic src_val_i,
    output logic      pin_o
);
    logic last_r = 1'b0;

    // No pull on this pin: an undriven wire shows a changing level, never a steady one
    always_comb begin
        if (unit_oe_i) begin
            pin_o = unit_pin_i;
        end else if (src_en_i) begin
            pin_o = src_val_i;
        end else begin
            pin_o = ~last_r;
        end
    end

    always_ff @(posedge clk_i) begin
        last_r <= pin_o;
    end
endmodule
`default_nettype wire

// File: ccu_unit_tb.sv
// Self-checking bench for the capture/compare unit.
// Assumes the single-cycle register port and the pin model beside the unit.
`timescale 1ns/1ps
`default_nettype none
module ccu_unit_tb;
    import ccu_pkg::*;
    logic         clk_i;
    logic         rst_n_i;
    logic         adc_enable_i;
    logic         src_en;
    logic         src_val;
    logic         pin_w;
    ccu_bus_req_s bus_i;
    logic [7:0]   rdata_o;
    logic [7:0]   rd_v;
    logic         pin_o;
    logic         pin_oe_o;
    logic         adc_start_o;
    logic         unit_irq_o;
    logic         time_base_irq_o;
    int           n_errors = 0;
    int           compares = 0;
    int           n_adc;
    logic [3:0]   modes [4] = '{CCU_MODE_CAP_FALL, CCU_MODE_CAP_RISE,
                                CCU_MODE_CAP_4TH, CCU_MODE_CAP_16TH};
    int           edges [4] = '{1, 1, 4, 16};

    ccu_unit dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .pin_i(pin_w), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .adc_enable_i(adc_enable_i),
        .adc_start_o(adc_start_o), .unit_irq_o(unit_irq_o),
        .time_base_irq_o(time_base_irq_o));

    ccu_pin_model pin_u (.clk_i(clk_i), .unit_pin_i(pin_o), .unit_oe_i(pin_oe_o),
        .src_en_i(src_en), .src_val_i(src_val), .pin_o(pin_w));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i.addr  <= a;
        bus_i.wdata <= d;
        bus_i.wr    <= 1'b1;
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus_i.addr <= a;
        bus_i.rd   <= 1'b1;
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        #1;
        rd_v = rdata_o;
        chk8(rd_v, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic set_tb(input logic [15:0] v);
        wr(CCU_ADDR_TB_LOW, v[7:0]);
        wr(CCU_ADDR_TB_HIGH, v[15:8]);
    endtask

    task automatic pulse();
        @(posedge clk_i);
        src_val <= 1'b1;
        cyc(6);
        @(posedge clk_i);
        src_val <= 1'b0;
        cyc(6);
    endtask

    // Time base stopped on each side of the run, so the match happens exactly once
    task automatic cmp_run(input logic [3:0] mode, input logic exp_pin);
        wr(CCU_ADDR_CTRL, {4'h0, mode});
        set_tb(16'h0100);
        wr(CCU_ADDR_FLAGS, 8'h00);
        wr(CCU_ADDR_TB_CTRL, 8'h01);
        cyc(10);
        wr(CCU_ADDR_TB_CTRL, 8'h00);
        chk1(pin_o, exp_pin);
        rchk(CCU_ADDR_FLAGS, 8'h04);
    endtask

    task automatic count_adc(input int n);
        n_adc = 0;
        repeat (n) begin
            @(posedge clk_i);
            #1;
            if (adc_start_o === 1'b1) n_adc++;
        end
    endtask

    initial begin
        repeat (30000) @(posedge clk_i);
        n_errors++;
        give_verdict();
    end

    initial begin
        rst_n_i = 1'b0;
        bus_i = '0;
        adc_enable_i = 1'b0;
        src_en = 1'b1;
        src_val = 1'b0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        cyc(1);
        chk1(pin_oe_o, 1'b0);
        rchk(CCU_ADDR_CTRL, CCU_CTRL_RST);
        wr(CCU_ADDR_VAL_LOW, 8'ha5);
        wr(CCU_ADDR_VAL_HIGH, 8'h5a);
        wr(CCU_ADDR_CTRL, 8'hff);
        rchk(CCU_ADDR_VAL_LOW, 8'ha5);
        rchk(CCU_ADDR_VAL_HIGH, 8'h5a);
        rchk(CCU_ADDR_CTRL, 8'hff & CCU_CTRL_MASK);
        rchk(8'h20, 8'h00);
        // Capture in every edge mode from a cleared prescaler
        for (int i = 0; i < 4; i++) begin
            wr(CCU_ADDR_CTRL, 8'h00);
            wr(CCU_ADDR_CTRL, {4'h0, modes[i]});
            wr(CCU_ADDR_FLAGS, 8'h00);
            set_tb({8'h12, 8'h30 + 8'(i)});
            repeat (edges[i] - 1) pulse();
            rchk(CCU_ADDR_FLAGS, 8'h00);
            @(posedge clk_i);
            src_val <= 1'b1;
            cyc(8);
            rchk(CCU_ADDR_FLAGS, modes[i] == CCU_MODE_CAP_FALL ? 8'h00 : 8'h04);
            @(posedge clk_i);
            src_val <= 1'b0;
            cyc(8);
            rchk(CCU_ADDR_FLAGS, 8'h04);
            rchk(CCU_ADDR_VAL_LOW, 8'h30 + 8'(i));
            rchk(CCU_ADDR_VAL_HIGH, 8'h12);
        end
        wr(CCU_ADDR_ENABLES, 8'h04);
        chk1(unit_irq_o, 1'b1);
        wr(CCU_ADDR_FLAGS, 8'h00);
        chk1(unit_irq_o, 1'b0);
        wr(CCU_ADDR_ENABLES, 8'h00);
        // Direct switch between prescalers keeps the count of two edges
        wr(CCU_ADDR_CTRL, 8'h00);
        wr(CCU_ADDR_CTRL, {4'h0, CCU_MODE_CAP_4TH});
        repeat (2) pulse();
        wr(CCU_ADDR_CTRL, {4'h0, CCU_MODE_CAP_16TH});
        wr(CCU_ADDR_FLAGS, 8'h00);
        repeat (13) pulse();
        rchk(CCU_ADDR_FLAGS, 8'h00);
        pulse();
        rchk(CCU_ADDR_FLAGS, 8'h04);
        // Pin as output: port writes make the edges
        wr(CCU_ADDR_CTRL, 8'h00);
        wr(CCU_ADDR_PORT_DATA, 8'h00);
        wr(CCU_ADDR_PORT_DIR, 8'hfb);
        @(posedge clk_i);
        src_en <= 1'b0;
        wr(CCU_ADDR_CTRL, {4'h0, CCU_MODE_CAP_RISE});
        wr(CCU_ADDR_FLAGS, 8'h00);
        set_tb(16'h4321);
        wr(CCU_ADDR_PORT_DATA, 8'h04);
        cyc(8);
        chk1(pin_o, 1'b1);
        wr(CCU_ADDR_PORT_DATA, 8'h00);
        // Time base runs while the edge passes the synchroniser, then stops
        set_tb(16'h86fc);
        wr(CCU_ADDR_TB_CTRL, 8'h01);
        wr(CCU_ADDR_PORT_DATA, 8'h04);
        wr(CCU_ADDR_TB_CTRL, 8'h00);
        rchk(CCU_ADDR_VAL_LOW, 8'h00);
        rchk(CCU_ADDR_VAL_HIGH, 8'h87);
        rchk(CCU_ADDR_FLAGS, 8'h04);
        // Compare actions against value 0x0105
        wr(CCU_ADDR_PORT_DATA, 8'h00);
        wr(CCU_ADDR_CTRL, 8'h00);
        wr(CCU_ADDR_VAL_LOW, 8'h05);
        wr(CCU_ADDR_VAL_HIGH, 8'h01);
        cmp_run(CCU_MODE_CMP_HIGH, 1'b1);
        cmp_run(CCU_MODE_CMP_LOW, 1'b0);
        cmp_run(CCU_MODE_CMP_HIGH, 1'b1);
        wr(CCU_ADDR_CTRL, 8'h00);
        wr(CCU_ADDR_CTRL, {4'h0, CCU_MODE_CMP_LOW});
        chk1(pin_o, 1'b0);
        wr(CCU_ADDR_PORT_DATA, 8'h04);
        cmp_run(CCU_MODE_CMP_SOFT, 1'b1);
        // Special trigger: value 0x0040 becomes the period
        wr(CCU_ADDR_PORT_DATA, 8'h00);
        wr(CCU_ADDR_CTRL, 8'h00);
        wr(CCU_ADDR_VAL_LOW, 8'h40);
        wr(CCU_ADDR_VAL_HIGH, 8'h00);
        wr(CCU_ADDR_ENABLES, 8'h01);
        @(posedge clk_i);
        adc_enable_i <= 1'b1;
        set_tb(16'h003a);
        wr(CCU_ADDR_FLAGS, 8'h00);
        wr(CCU_ADDR_CTRL, {4'h0, CCU_MODE_CMP_TRIG});
        wr(CCU_ADDR_TB_CTRL, 8'h01);
        count_adc(100);
        chk8(8'(n_adc), 8'h02);
        chk1(time_base_irq_o, 1'b0);
        rchk(CCU_ADDR_TB_HIGH, 8'h00);
        rchk(CCU_ADDR_FLAGS, 8'h04);
        @(posedge clk_i);
        adc_enable_i <= 1'b0;
        count_adc(80);
        chk8(8'(n_adc), 8'h00);
        wr(CCU_ADDR_TB_CTRL, 8'h00);
        // Trigger at the top of the count stands in for the rollover
        wr(CCU_ADDR_VAL_LOW, 8'hff);
        wr(CCU_ADDR_VAL_HIGH, 8'hff);
        set_tb(16'hfff8);
        wr(CCU_ADDR_FLAGS, 8'h00);
        wr(CCU_ADDR_TB_CTRL, 8'h01);
        cyc(12);
        wr(CCU_ADDR_TB_CTRL, 8'h00);
        chk1(time_base_irq_o, 1'b0);
        rchk(CCU_ADDR_FLAGS, 8'h04);
        wr(CCU_ADDR_CTRL, 8'h00);
        set_tb(16'hfffe);
        wr(CCU_ADDR_TB_CTRL, 8'h01);
        cyc(4);
        chk1(time_base_irq_o, 1'b1);
        wr(CCU_ADDR_TB_CTRL, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
